// ---- include/fcu_pkg.sv ----
// shared constants for the float compare unit
`default_nettype none
package fcu_pkg;
	// operation codes seen on the issue port
	localparam logic [7:0] FCU_OP_GEQ = 8'h92;
	localparam logic [7:0] FCU_OP_EQL = 8'h94;
	localparam logic [7:0] FCU_OP_EQL_FLAGS = 8'h95;
	// exception vector layout
	localparam int FCU_FLAG_W = 7;
	localparam int FCU_BIT_DIVIDE_BY_ZERO = 0;
	localparam int FCU_BIT_ROUNDED_RESULT = 1;
	localparam int FCU_BIT_RESULT_TOO_SMALL = 2;
	localparam int FCU_BIT_RESULT_TOO_LARGE = 3;
	localparam int FCU_BIT_BAD_OPERATION = 4;
	localparam int FCU_BIT_INPUT_FLUSHED = 5;
	localparam int FCU_BIT_OUTPUT_FLUSHED = 6;
	// single precision field layout
	localparam int FCU_SIGN_BIT = 31;
	localparam int FCU_EXP_HI = 30;
	localparam int FCU_EXP_LO = 23;
	localparam int FCU_MANT_HI = 22;
	localparam logic [7:0] FCU_EXP_ALL_ONES = 8'hff;
	localparam logic [7:0] FCU_EXP_ZERO = 8'h00;
	localparam logic [22:0] FCU_MANT_ZERO = 23'h000000;
	// register byte offsets on the bus
	localparam logic [11:0] FCU_OFS_STATUS = 12'h000;
	localparam logic [11:0] FCU_OFS_LAST_RESULT = 12'h004;
	localparam logic [11:0] FCU_OFS_WRITE_COUNT = 12'h008;
	localparam int FCU_OFS_W = 12;
	// reset values
	localparam logic [6:0] FCU_STATUS_RESET = 7'h00;
	localparam logic [31:0] FCU_WORD_RESET = 32'h00000000;
	// cycles from issue to result
	localparam int FCU_LATENCY_CYCLES = 1;
endpackage : fcu_pkg
`default_nettype wire

// ---- include/fcu_cmp_if.sv ----
// operands and compare outcomes between the unit and its compare core
`timescale 1ns/1ps
`default_nettype none
interface fcu_cmp_if;
	logic [31:0] first_operand; // issued first source value
	logic [31:0] second_operand; // issued second source value
	logic equal_result; // 1 when operands compare equal
	logic geq_result; // 1 when first is at least second
	logic [6:0] equal_flags; // exceptions raised by the equality compare
	logic [6:0] geq_flags; // exceptions raised by the ordered compare
	modport core (
		input first_operand,
		input second_operand,
		output equal_result,
		output geq_result,
		output equal_flags,
		output geq_flags
	);
	modport user (
		output first_operand,
		output second_operand,
		input equal_result,
		input geq_result,
		input equal_flags,
		input geq_flags
	);
endinterface : fcu_cmp_if
`default_nettype wire

// ---- hw/fcu_compare_core.sv ----
// combinational single precision equal and greater-or-equal compare
`timescale 1ns/1ps
`default_nettype none
module fcu_compare_core (
	// operands in, outcomes out
	fcu_cmp_if.core cmp
);
	// exponent zero with a nonzero fraction
	function automatic logic is_denorm(input logic [31:0] x);
		is_denorm = (x[fcu_pkg::FCU_EXP_HI:fcu_pkg::FCU_EXP_LO] ==
			fcu_pkg::FCU_EXP_ZERO) &&
			(x[fcu_pkg::FCU_MANT_HI:0] != fcu_pkg::FCU_MANT_ZERO);
	endfunction : is_denorm

	// exponent all ones with a nonzero fraction, quiet or signalling
	function automatic logic is_nan(input logic [31:0] x);
		is_nan = (x[fcu_pkg::FCU_EXP_HI:fcu_pkg::FCU_EXP_LO] ==
			fcu_pkg::FCU_EXP_ALL_ONES) &&
			(x[fcu_pkg::FCU_MANT_HI:0] != fcu_pkg::FCU_MANT_ZERO);
	endfunction : is_nan

	// magnitude without sign; a flushed denormal becomes zero here
	function automatic logic [30:0] magnitude(input logic [31:0] x);
		if (is_denorm(x)) begin
			magnitude = 31'h00000000;
		end else begin
			magnitude = x[fcu_pkg::FCU_EXP_HI:0];
		end
	endfunction : magnitude

	logic [30:0] mag_a; // flushed magnitude of first operand
	logic [30:0] mag_b; // flushed magnitude of second operand
	logic neg_a; // first operand negative and nonzero
	logic neg_b; // second operand negative and nonzero
	logic any_nan; // either operand not a number
	logic any_flush; // either operand was a denormal
	logic ordered_geq; // geq outcome ignoring nan

	// sign only matters for nonzero values, so +0 and -0 tie
	always_comb begin
		mag_a = magnitude(cmp.first_operand); // [RULE3] [RULE8] [RULE9]
		mag_b = magnitude(cmp.second_operand); // [RULE3] [RULE8] [RULE9]
		neg_a = cmp.first_operand[fcu_pkg::FCU_SIGN_BIT] && (mag_a != 31'h0);
		neg_b = cmp.second_operand[fcu_pkg::FCU_SIGN_BIT] && (mag_b != 31'h0);
		any_nan = is_nan(cmp.first_operand) || is_nan(cmp.second_operand);
		any_flush = is_denorm(cmp.first_operand) ||
			is_denorm(cmp.second_operand);
		// order by sign first, then magnitude, reversed when negative
		if (neg_a != neg_b) begin
			ordered_geq = neg_b;
		end else if (neg_a) begin
			ordered_geq = (mag_a <= mag_b);
		end else begin
			ordered_geq = (mag_a >= mag_b);
		end
	end

	// outcomes; nan answers 0 for both compares
	always_comb begin
		cmp.equal_result = !any_nan && (mag_a == mag_b) &&
			(neg_a == neg_b); // [RULE1] [RULE16]
		cmp.geq_result = !any_nan && ordered_geq; // [RULE2] [RULE16]
		cmp.equal_flags = 7'h00;
		cmp.geq_flags = 7'h00;
		// equality is quiet: no invalid even on nan
		cmp.equal_flags[fcu_pkg::FCU_BIT_INPUT_FLUSHED] = any_flush; // [RULE9]
		cmp.geq_flags[fcu_pkg::FCU_BIT_INPUT_FLUSHED] = any_flush; // [RULE8]
		cmp.geq_flags[fcu_pkg::FCU_BIT_BAD_OPERATION] = any_nan; // [RULE16]
	end
endmodule : fcu_compare_core
`default_nettype wire

// ---- hw/fcu_compare_unit.sv ----
// float compare unit: issue port, sticky status word and bus slave
`timescale 1ns/1ps
`default_nettype none
// What this block does
// [RULE1] equal compare writes 1 else 0
// [RULE2] geq compare writes 1 when first at least second
// [RULE3] operands single precision, result plain integer
// [RULE4] flags compare stores exception vector, not outcome
// [RULE5] vector bits six to zero, upper bits zero
// [RULE6] flags compare result is integer bit vector
// [RULE7] flags compare never touches status word
// [RULE8] boolean compares flush denormals, set input flush
// [RULE9] flags compare flushes denormals, sets vector bit
// [RULE10] boolean compare exceptions set status word flags
// [RULE11] status flags sticky, only explicit write clears
// [RULE12] status update lands with destination write
// [RULE13] simultaneous updates OR with previous flag value
// [RULE14] false guard blocks destination and status flags
// [RULE15] false guard keeps flags compare destination
// [RULE16] nan returns 0; only geq raises invalid
// [RULE17] one cycle latency, new operation every cycle
module fcu_compare_unit (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// issue from the core
	input wire logic issue_valid,
	input wire logic [7:0] issue_opcode,
	input wire logic [31:0] first_source_register,
	input wire logic [31:0] second_source_register,
	input wire logic guard_present,
	input wire logic [31:0] guard_value,
	// flag updates from other float units in the same cycle
	input wire logic other_flags_valid,
	input wire logic [6:0] other_flags,
	// writeback
	output logic result_valid,
	output logic result_write,
	output logic [31:0] result_data,
	// sticky flags
	output logic [6:0] processor_status_word,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata
);
	logic rst_meta_n; // first reset stage, read only by the second
	logic rst_n; // released reset used everywhere else

	// async assert, two-stage release to avoid metastable exit
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rst_meta_n <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_n <= 1'b1;
			rst_n <= rst_meta_n;
		end
	end

	// compare core hookup
	fcu_cmp_if cmp ();

	fcu_compare_core u_core (
		.cmp(cmp.core)
	);

	// operands go straight to the core; no holding register needed
	assign cmp.first_operand = first_source_register; // [RULE3]
	assign cmp.second_operand = second_source_register; // [RULE3]

	// decode of the issued operation
	logic op_eql; // boolean equal
	logic op_geq; // boolean greater-or-equal
	logic op_flags; // flags-only equal
	logic guard_ok; // guard absent or its lsb set
	logic op_known; // one of the three handled codes
	logic plain_write; // boolean compare that commits
	logic flags_write; // flags compare that commits

	// unhandled codes are ignored, leaving writeback quiet
	always_comb begin
		op_eql = issue_valid && (issue_opcode == fcu_pkg::FCU_OP_EQL);
		op_geq = issue_valid && (issue_opcode == fcu_pkg::FCU_OP_GEQ);
		op_flags = issue_valid &&
			(issue_opcode == fcu_pkg::FCU_OP_EQL_FLAGS);
		guard_ok = !guard_present || guard_value[0]; // [RULE14] [RULE15]
		op_known = op_eql || op_geq || op_flags;
		plain_write = (op_eql || op_geq) && guard_ok; // [RULE14]
		flags_write = op_flags && guard_ok; // [RULE15]
	end

	// value to write back
	logic [31:0] next_result_data; // destination value of this issue
	logic [6:0] compare_flags; // flags raised by a committing boolean op

	// boolean ops give 0/1, flags op gives the zero-extended vector
	always_comb begin
		next_result_data = result_data;
		compare_flags = 7'h00;
		if (op_eql) begin
			next_result_data = {31'h00000000, cmp.equal_result}; // [RULE1]
		end else if (op_geq) begin
			next_result_data = {31'h00000000, cmp.geq_result}; // [RULE2]
		end else if (op_flags) begin
			// upper bits forced zero [RULE4] [RULE5] [RULE6]
			next_result_data = {25'h0000000, cmp.equal_flags};
		end
		if (plain_write && op_eql) begin
			compare_flags = cmp.equal_flags; // [RULE10]
		end else if (plain_write && op_geq) begin
			compare_flags = cmp.geq_flags; // [RULE10]
		end
		// flags op contributes nothing to the status word [RULE7]
	end

	// bus address phase capture
	logic bus_take; // valid transfer accepted this cycle
	logic wr_pending; // write data phase in progress
	logic [11:0] wr_addr; // offset of the pending write
	logic status_write; // pending write hits the status word

	assign bus_take = hsel && htrans[1] && hready;
	assign status_write = wr_pending && (wr_addr == fcu_pkg::FCU_OFS_STATUS);

	// remember a write so its data can be taken in the next cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_pending <= 1'b0;
			wr_addr <= 12'h000;
		end else begin
			wr_pending <= bus_take && hwrite;
			wr_addr <= haddr[11:0];
		end
	end

	// next status word
	logic [6:0] next_status; // status word after this edge
	logic [6:0] set_flags; // all sets arriving this cycle

	// sets win over a clearing write in the same cycle
	always_comb begin
		set_flags = compare_flags; // [RULE10] [RULE12]
		if (other_flags_valid) begin
			set_flags = set_flags | other_flags; // [RULE13]
		end
		if (status_write) begin
			// only an explicit write may drop a flag [RULE11]
			next_status = hwdata[6:0] | set_flags;
		end else begin
			next_status = processor_status_word | set_flags; // [RULE13]
		end
	end

	// sticky flags register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			processor_status_word <= fcu_pkg::FCU_STATUS_RESET;
		end else begin
			processor_status_word <= next_status; // [RULE11] [RULE12]
		end
	end

	// writeback registers, one cycle after issue
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			result_valid <= 1'b0;
			result_write <= 1'b0;
			result_data <= fcu_pkg::FCU_WORD_RESET;
		end else begin
			result_valid <= op_known; // [RULE17]
			result_write <= plain_write || flags_write; // [RULE14] [RULE15]
			// a false guard leaves the old value standing
			if (plain_write || flags_write) begin
				result_data <= next_result_data; // [RULE12] [RULE17]
			end
		end
	end

	// count of committed writebacks, visible on the bus
	logic [31:0] write_count; // wraps at the top
	logic [31:0] next_write_count; // value after this edge

	always_comb begin
		next_write_count = write_count;
		if (plain_write || flags_write) begin
			next_write_count = write_count + 32'h00000001;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			write_count <= fcu_pkg::FCU_WORD_RESET;
		end else begin
			write_count <= next_write_count;
		end
	end

	// read mux; uses next values so a read right after a write is current
	logic [31:0] next_rdata; // data for the following data phase

	always_comb begin
		next_rdata = 32'h00000000;
		case (haddr[fcu_pkg::FCU_OFS_W-1:0])
			fcu_pkg::FCU_OFS_STATUS: begin
				next_rdata = {25'h0000000, next_status};
			end
			fcu_pkg::FCU_OFS_LAST_RESULT: begin
				if (plain_write || flags_write) begin
					next_rdata = next_result_data;
				end else begin
					next_rdata = result_data;
				end
			end
			fcu_pkg::FCU_OFS_WRITE_COUNT: begin
				next_rdata = next_write_count;
			end
			default: begin
				// unmapped offsets read as zero
				next_rdata = 32'h00000000;
			end
		endcase
	end

	// zero wait state answers; hresp stays okay for every address
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			hrdata <= 32'h00000000;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			if (bus_take && !hwrite) begin
				hrdata <= next_rdata;
			end
		end
	end

	// hsize is not checked: only whole word transfers are expected
	logic unused_bits; // keeps unread inputs visible to readers
	assign unused_bits = ^{hsize, haddr[31:12], guard_value[31:1]};
endmodule : fcu_compare_unit
`default_nettype wire

// ---- sim/fcu_compare_unit_chk.sv ----
// assertions on the float compare unit ports
`timescale 1ns/1ps
`default_nettype none
module fcu_compare_unit_chk (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// issue side
	input wire logic issue_valid,
	input wire logic [7:0] issue_opcode,
	input wire logic guard_present,
	input wire logic [31:0] guard_value,
	input wire logic other_flags_valid,
	input wire logic [6:0] other_flags,
	// writeback and flags
	input wire logic result_write,
	input wire logic result_valid,
	input wire logic [31:0] result_data,
	input wire logic [6:0] processor_status_word,
	// bus address phase
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);
	logic known; // an opcode the unit executes
	logic commit; // guard lets the op write
	logic is_flags; // flags-only equality
	logic wr_pend; // status write in its data phase
	assign known = issue_valid && (issue_opcode == fcu_pkg::FCU_OP_GEQ
		|| issue_opcode == fcu_pkg::FCU_OP_EQL || is_flags);
	assign commit = !guard_present || guard_value[0];
	assign is_flags = issue_opcode == fcu_pkg::FCU_OP_EQL_FLAGS;
	// the status load lands one edge after the address phase
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wr_pend <= 1'b0;
		end else begin
			wr_pend <= hsel && htrans[1] && hready && hwrite
				&& haddr[11:0] == fcu_pkg::FCU_OFS_STATUS;
		end
	end
	chk_valid_timing: assert property (result_valid == $past(known))
		else $error("result valid not one cycle after issue");
	chk_guard_commit: assert property (known |=> result_write == $past(commit))
		else $error("destination write does not follow guard");
	chk_guard_hold: assert property (known && !commit |=> $stable(result_data))
		else $error("false guard changed the destination");
	chk_bool_int: assert property (result_write && !$past(is_flags)
		|-> result_data[31:1] == 31'h0)
		else $error("boolean result not 0 or 1");
	chk_vector_upper: assert property (result_write && $past(is_flags)
		|-> result_data[31:7] == 25'h0)
		else $error("flag vector upper bits not zero");
	chk_flags_quiet: assert property (known && is_flags && !other_flags_valid
		&& !wr_pend |=> $stable(processor_status_word))
		else $error("flags-only compare touched status");
	chk_flags_sticky: assert property ($past(wr_pend) || (processor_status_word
		& $past(processor_status_word)) == $past(processor_status_word))
		else $error("status flag cleared without a write");
	chk_other_or: assert property (other_flags_valid |=> (processor_status_word
		& $past(other_flags)) == $past(other_flags))
		else $error("other unit flags not ORed in");
	// main scenarios reached
	cover property (known && !commit);
	cover property (known && is_flags && commit);
	cover property (wr_pend);
endmodule : fcu_compare_unit_chk
`default_nettype wire

// ---- sim/fcu_core_model.sv ----
// core writeback model holding the destination register
`timescale 1ns/1ps
`default_nettype none
module fcu_core_model (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// writeback from the unit
	input wire logic result_write,
	input wire logic [31:0] result_data,
	// destination as software sees it
	output logic [31:0] dest_reg
);
	// only a committed write may replace the destination
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			dest_reg <= 32'h00000000;
		end else if (result_write) begin
			dest_reg <= result_data;
		end
	end
endmodule : fcu_core_model
`default_nettype wire

// ---- sim/fcu_compare_unit_tb.sv ----
// self-checking bench for the float compare unit
`timescale 1ns/1ps
`default_nettype none
module fcu_compare_unit_tb;
	localparam logic [7:0] EQ = fcu_pkg::FCU_OP_EQL;
	localparam logic [7:0] GE = fcu_pkg::FCU_OP_GEQ;
	localparam logic [7:0] FL = fcu_pkg::FCU_OP_EQL_FLAGS;
	localparam logic [31:0] THREE = 32'h40400000;
	localparam logic [31:0] ONE = 32'h3f800000;
	localparam logic [31:0] NAN = 32'hffffffff;
	localparam logic [31:0] PINF = 32'h7f800000;
	localparam logic [31:0] NINF = 32'hff800000;
	localparam logic [31:0] DEN = 32'h00400000; // denormal
	localparam logic [6:0] INPUT_FLUSHED_FLAG = 7'h1 << fcu_pkg::FCU_BIT_INPUT_FLUSHED;
	localparam logic [6:0] BAD_OPERATION_FLAG = 7'h1 << fcu_pkg::FCU_BIT_BAD_OPERATION;
	localparam logic [6:0] DIVIDE_BY_ZERO_FLAG = 7'h1 << fcu_pkg::FCU_BIT_DIVIDE_BY_ZERO;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic issue_valid = 1'b0;
	logic [7:0] issue_opcode = 8'h00;
	logic [31:0] first_source_register = 32'h0;
	logic [31:0] second_source_register = 32'h0;
	logic guard_present = 1'b0;
	logic [31:0] guard_value = 32'h0;
	logic other_flags_valid = 1'b0;
	logic [6:0] other_flags = 7'h00;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'b00;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'b010; // whole words only
	logic [31:0] hwdata = 32'h0;
	logic result_valid, result_write, hreadyout, hresp;
	logic [31:0] result_data, hrdata, dest_reg, rd;
	logic [6:0] processor_status_word;
	logic [6:0] exp_psw = 7'h00; // expected sticky flags
	wire logic hready; // single slave drives the bus ready
	int fail_count = 0;
	int n_checks = 0;
	assign hready = hreadyout;
	always #50 clk = ~clk;
	fcu_compare_unit uut (.*);
	fcu_core_model model (.*);
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	// one issue, judged one edge later; g is {present, guard bit 0}
	task automatic op(input logic [7:0] c, input logic [31:0] a, b,
		input logic [1:0] g, input logic [6:0] of, input logic [31:0] ed);
		@(posedge clk);
		issue_valid <= 1'b1;
		issue_opcode <= c;
		first_source_register <= a;
		second_source_register <= b;
		guard_present <= g[1];
		guard_value <= {31'h7fffffff, g[0]}; // upper bits must not matter
		other_flags_valid <= |of;
		other_flags <= of;
		@(posedge clk);
		issue_valid <= 1'b0;
		other_flags_valid <= 1'b0;
		#1;
		cmp({31'h0, result_valid}, {31'h0, c == EQ || c == GE || c == FL});
		cmp(result_data, ed);
		cmp({25'h0, processor_status_word}, {25'h0, exp_psw});
	endtask : op
	// single ahb-lite transfer; read data lands in rd
	task automatic ahb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {20'h0, a};
		hwrite <= w;
		do @(posedge clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		rd = hrdata;
	endtask : ahb
	task automatic t_equal;
		op(EQ, THREE, 32'h0, 2'b00, 7'h0, 32'h0);
		op(EQ, THREE, THREE, 2'b00, 7'h0, 32'h1);
		op(EQ, THREE, NAN, 2'b00, 7'h0, 32'h0);
		op(EQ, PINF, NINF, 2'b00, 7'h0, 32'h0);
		op(EQ, 32'h80000000, 32'h0, 2'b00, 7'h0, 32'h1);
		exp_psw = INPUT_FLUSHED_FLAG;
		op(EQ, ONE, DEN, 2'b00, 7'h0, 32'h0);
	endtask : t_equal
	task automatic t_geq;
		op(GE, THREE, THREE, 2'b00, 7'h0, 32'h1);
		op(GE, ONE, THREE, 2'b00, 7'h0, 32'h0);
		op(GE, PINF, NINF, 2'b00, 7'h0, 32'h1);
		op(GE, ONE, DEN, 2'b00, 7'h0, 32'h1);
		exp_psw = INPUT_FLUSHED_FLAG | BAD_OPERATION_FLAG;
		op(GE, THREE, NAN, 2'b00, 7'h0, 32'h0);
	endtask : t_geq
	task automatic t_status;
		ahb(1'b1, fcu_pkg::FCU_OFS_STATUS, 32'h0);
		exp_psw = 7'h00;
		ahb(1'b0, fcu_pkg::FCU_OFS_STATUS, 32'h0);
		cmp(rd, 32'h0);
		op(FL, ONE, DEN, 2'b00, 7'h0, {25'h0, INPUT_FLUSHED_FLAG});
		op(FL, THREE, NAN, 2'b00, 7'h0, 32'h0);
		exp_psw = BAD_OPERATION_FLAG | DIVIDE_BY_ZERO_FLAG;
		op(GE, THREE, NAN, 2'b00, DIVIDE_BY_ZERO_FLAG, 32'h0);
		op(EQ, ONE, ONE, 2'b00, 7'h0, 32'h1);
		ahb(1'b0, fcu_pkg::FCU_OFS_STATUS, 32'h0);
		cmp(rd, {25'h0, exp_psw});
		ahb(1'b0, 12'h040, 32'h0);
		cmp(rd, 32'h0);
	endtask : t_status
	task automatic t_guard;
		op(EQ, ONE, ONE, 2'b11, 7'h0, 32'h1);
		op(EQ, ONE, DEN, 2'b10, 7'h0, 32'h1);
		op(FL, ONE, DEN, 2'b10, 7'h0, 32'h1);
		@(posedge clk);
		#1;
		cmp(dest_reg, 32'h1);
		op(8'h93, ONE, ONE, 2'b00, 7'h0, 32'h1);
		op(GE, ONE, THREE, 2'b11, 7'h0, 32'h0);
	endtask : t_guard
	task automatic give_verdict;
		if (fail_count == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : give_verdict
	// reset, then the scenarios in turn
	initial begin
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		repeat (3) @(posedge clk);
		t_equal();
		t_geq();
		t_status();
		t_guard();
		give_verdict();
	end
	// watchdog against a hung bus wait
	initial begin
		#200000;
		fail_count++;
		give_verdict();
	end
endmodule : fcu_compare_unit_tb
bind fcu_compare_unit fcu_compare_unit_chk chk (.*);
`default_nettype wire
